// *** verilog/pwc_top.sv ***
// periodic wakeup timer, low-voltage detect/warning and stop-mode control register bank
// Function
// - wakeup flag bit 7 sets at the end of every selected period
// - writing one to bit 6 clears wakeup flag; bit reads zero
// - bit 5 selects 1 kHz (zero) or 32 kHz (one) timer source
// - wakeup interrupt request is flag and enable bit 4
// - period code bits 2:0; code zero disables the timer
// - 1 kHz codes 1..7 give 8,32,64,128,256,512,1024 ms
// - 32 kHz codes 1..7 count 256 to 32768 source periods
// - first timeout may end up to one 1 kHz period early; a tick in the write cycle counts on from the old count instead
// - detect flag bit 7 sets on a detect event while enabled
// - writing one to bit 6 clears detect flag; reads zero
// - detect interrupt requested while flag set and bit 5 one
// - reset-enable bit 4 with detect enabled forces full reset on flag
// - bit 3 keeps detection active in stop mode
// - write-once bit 2 enables detect logic; otherwise bits 5:3 inert
// - bit 0 drives the bandgap reference buffer enable
// - write-once bits accept only the first write after reset
// - warning flag bit 7 shows warning present or seen since clear
// - warning acknowledge clears flag only when warning is gone
// - bit 5 detect trip, bit 4 warning trip; one selects high
// - power-down flag bit 3 sets on stop2 recovery; bit 2 clears it
// - write-once bit 0 selects stop3 (zero) or stop2 (one)
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pwc_top #(
  parameter int CNT_W = 16
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // slow timer ticks, one core_clk pulse per source period
  input  wire logic        tick_1k,
  input  wire logic        tick_32k,
  // analog and power-mode status from the supply monitor
  input  wire logic        detect_level,
  input  wire logic        warning_level,
  input  wire logic        in_stop,
  input  wire logic        stop2_recovered,
  // control outputs
  output logic             wakeup_irq,
  output logic             detect_irq,
  output logic             detect_reset_req,
  output logic             detect_active,
  output logic             detect_trip_high,
  output logic             warning_trip_high,
  output logic             bandgap_buffer_enable,
  output logic             stop2_select
);
  import pwc_pkg::*;

  // refuse widths that cannot hold a 32768-tick period or do not fit the status word
  if (CNT_W < 15 || CNT_W > 32) begin : g_bad_cnt_w
    $error("CNT_W must lie between 15 and 32");
  end

  // registered state
  logic                 wt_flag_q, wt_flag_d;
  logic                 wt_src_q, wt_src_d;
  logic                 wt_ie_q, wt_ie_d;
  logic [2:0]           wt_per_q, wt_per_d;
  logic [CNT_W-1:0]     wt_cnt_q, wt_cnt_d;
  logic                 det_flag_q, det_flag_d;
  logic                 det_ie_q, det_ie_d;
  logic                 det_re_q, det_re_d;
  logic                 det_se_q, det_se_d;
  logic                 det_en_q, det_en_d;
  logic                 bg_q, bg_d;
  logic                 p1_wr_q, p1_wr_d;
  logic                 warn_flag_q, warn_flag_d;
  logic                 dtrip_q, dtrip_d;
  logic                 wtrip_q, wtrip_d;
  logic                 ppd_flag_q, ppd_flag_d;
  logic                 partial_power_down_control_q, partial_power_down_control_d;
  logic                 p2_wr_q, p2_wr_d;
  logic [31:0]          dat_q, dat_d;
  logic                 ack_q, ack_d;
  logic                 irq_w_q, irq_d_q, rst_req_q, act_q;
  pwc_bus_state_t       bus_q, bus_d;
  logic                 irq_w_d, irq_d_d, rst_req_d, act_d;
  logic [7:0]           rd_wakeup, rd_p1, rd_p2;

  logic                 wr, rd_en;
  logic [7:0]           wdat;
  logic                 tick;
  logic [CNT_W-1:0]     limit;
  logic                 det_live;
  logic                 hit_wakeup, hit_p1, hit_p2, hit_stat;

  // a write lands on the ack edge only, low byte lane
  always_comb begin
    hit_wakeup = (wb_adr_i == PWC_OFS_WAKEUP);
    hit_p1     = (wb_adr_i == PWC_OFS_PMC1);
    hit_p2     = (wb_adr_i == PWC_OFS_PMC2);
    hit_stat   = (wb_adr_i == PWC_OFS_STATUS);
    rd_en      = wb_cyc_i && wb_stb_i && (bus_q == PWC_BUS_IDLE);
    wr         = rd_en && wb_we_i && wb_sel_i[0];
    wdat       = wb_dat_i[7:0];
  end

  // period end value in source ticks; 1 kHz ms table, 32 kHz power-of-two table
  always_comb begin
    tick  = wt_src_q ? tick_32k : tick_1k;
    limit = '0;
    if (wt_src_q) begin
      case (wt_per_q)
        3'h1:    limit = CNT_W'(256 - 1);
        3'h2:    limit = CNT_W'(1024 - 1);
        3'h3:    limit = CNT_W'(2048 - 1);
        3'h4:    limit = CNT_W'(4096 - 1);
        3'h5:    limit = CNT_W'(8192 - 1);
        3'h6:    limit = CNT_W'(16384 - 1);
        3'h7:    limit = CNT_W'(32768 - 1);
        default: limit = '0;
      endcase
    end else begin
      case (wt_per_q)
        3'h1:    limit = CNT_W'(WT_SLOW_TICKS_1K_8MS - 1);
        3'h2:    limit = CNT_W'(32 - 1);
        3'h3:    limit = CNT_W'(64 - 1);
        3'h4:    limit = CNT_W'(128 - 1);
        3'h5:    limit = CNT_W'(256 - 1);
        3'h6:    limit = CNT_W'(512 - 1);
        3'h7:    limit = CNT_W'(1024 - 1);
        default: limit = '0;
      endcase
    end
  end

  // wakeup timer and its register; set beats the acknowledge
  always_comb begin
    wt_src_d  = wt_src_q;
    wt_ie_d   = wt_ie_q;
    wt_per_d  = wt_per_q;
    wt_cnt_d  = wt_cnt_q;
    wt_flag_d = wt_flag_q;
    if (wr && hit_wakeup) begin
      wt_src_d = wdat[WT_SRC_BIT];
      wt_ie_d  = wdat[WT_IE_BIT];
      wt_per_d = wdat[WT_PER_MSB:0];
      wt_cnt_d = '0; // restart; first tick may come early
      if (wdat[WT_ACK_BIT]) wt_flag_d = 1'b0;
    end
    // counting slow ticks, not core cycles, keeps the counter narrow
    // limitation: a tick lost to a source switch lengthens that period only
    if (wt_per_q == 3'h0) begin
      wt_cnt_d = '0;
    end else if (tick) begin
      if (wt_cnt_q >= limit) begin
        wt_cnt_d  = '0;
        wt_flag_d = 1'b1;
      end else begin
        wt_cnt_d = wt_cnt_q + 1'b1;
      end
    end
  end

  // detect register: write-once bits latch on first write after reset
  always_comb begin
    det_live   = det_en_q && (!in_stop || det_se_q);
    det_flag_d = det_flag_q;
    det_ie_d   = det_ie_q;
    det_se_d   = det_se_q;
    bg_d       = bg_q;
    det_re_d   = det_re_q;
    det_en_d   = det_en_q;
    p1_wr_d    = p1_wr_q;
    if (wr && hit_p1) begin
      det_ie_d = wdat[P1_IE_BIT];
      det_se_d = wdat[P1_SE_BIT];
      bg_d     = wdat[P1_BG_BIT];
      if (!p1_wr_q) begin
        det_re_d = wdat[P1_RE_BIT];
        det_en_d = wdat[P1_EN_BIT];
        p1_wr_d  = 1'b1;
      end
      if (wdat[P1_ACK_BIT]) det_flag_d = 1'b0;
    end
    if (det_live && detect_level) det_flag_d = 1'b1;
  end

  // warning and stop-mode register
  always_comb begin
    warn_flag_d = warn_flag_q;
    dtrip_d     = dtrip_q;
    wtrip_d     = wtrip_q;
    ppd_flag_d  = ppd_flag_q;
    partial_power_down_control_d      = partial_power_down_control_q;
    p2_wr_d     = p2_wr_q;
    if (wr && hit_p2) begin
      dtrip_d = wdat[P2_DTRIP_BIT];
      wtrip_d = wdat[P2_WTRIP_BIT];
      if (wdat[P2_WACK_BIT] && !warning_level) warn_flag_d = 1'b0;
      if (wdat[P2_PACK_BIT]) ppd_flag_d = 1'b0;
      if (!p2_wr_q) begin
        partial_power_down_control_d  = wdat[P2_PARTIAL_POWER_DOWN_CONTROL_BIT];
        p2_wr_d = 1'b1;
      end
    end
    if (warning_level) warn_flag_d = 1'b1;
    if (stop2_recovered) ppd_flag_d = 1'b1;
  end

  // bus answer: ack one cycle after request, then one idle cycle
  always_comb begin
    bus_d = bus_q;
    ack_d = 1'b0;
    dat_d = dat_q;
    case (bus_q)
      PWC_BUS_IDLE: begin
        if (rd_en) begin
          ack_d = 1'b1;
          bus_d = PWC_BUS_ACK;
          dat_d = '0; // unmapped and reserved read zero
          if (hit_wakeup) dat_d[7:0] = rd_wakeup;
          if (hit_p1)     dat_d[7:0] = rd_p1;
          if (hit_p2)     dat_d[7:0] = rd_p2;
          if (hit_stat)   dat_d[CNT_W-1:0] = wt_cnt_q; // live timer count
        end
      end
      PWC_BUS_ACK: bus_d = PWC_BUS_IDLE;
      default:     bus_d = PWC_BUS_IDLE;
    endcase
  end

  // wakeup read image; acknowledge and spare positions stay zero
  always_comb begin
    rd_wakeup               = 8'h00;
    rd_wakeup[WT_FLAG_BIT]  = wt_flag_q;
    rd_wakeup[WT_SRC_BIT]   = wt_src_q;
    rd_wakeup[WT_IE_BIT]    = wt_ie_q;
    rd_wakeup[WT_PER_MSB:0] = wt_per_q;
  end

  // detect read image; acknowledge and reserved bit 1 read zero
  always_comb begin
    rd_p1              = 8'h00;
    rd_p1[P1_FLAG_BIT] = det_flag_q;
    rd_p1[P1_IE_BIT]   = det_ie_q;
    rd_p1[P1_RE_BIT]   = det_re_q;
    rd_p1[P1_SE_BIT]   = det_se_q;
    rd_p1[P1_EN_BIT]   = det_en_q;
    rd_p1[P1_BG_BIT]   = bg_q;
  end

  // warning and stop read image; both acknowledges read zero
  always_comb begin
    rd_p2               = 8'h00;
    rd_p2[P2_WFLAG_BIT] = warn_flag_q;
    rd_p2[P2_DTRIP_BIT] = dtrip_q;
    rd_p2[P2_WTRIP_BIT] = wtrip_q;
    rd_p2[P2_PFLAG_BIT] = ppd_flag_q;
    rd_p2[P2_PARTIAL_POWER_DOWN_CONTROL_BIT]  = partial_power_down_control_q;
  end

  // output next values from next state, so pins track the registers without lag
  always_comb begin
    irq_w_d   = wt_flag_d && wt_ie_d;
    irq_d_d   = det_flag_d && det_ie_d && det_en_d;
    rst_req_d = det_flag_d && det_re_d && det_en_d;
    act_d     = det_en_d && (!in_stop || det_se_d);
  end

  // wakeup timer registers; reset takes constants only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wt_flag_q <= PWC_RST_WAKEUP[WT_FLAG_BIT];
      wt_src_q  <= PWC_RST_WAKEUP[WT_SRC_BIT];
      wt_ie_q   <= PWC_RST_WAKEUP[WT_IE_BIT];
      wt_per_q  <= PWC_RST_WAKEUP[WT_PER_MSB:0];
      wt_cnt_q  <= '0;
    end else begin
      wt_flag_q <= wt_flag_d;
      wt_src_q  <= wt_src_d;
      wt_ie_q   <= wt_ie_d;
      wt_per_q  <= wt_per_d;
      wt_cnt_q  <= wt_cnt_d;
    end
  end

  // detect registers; reset re-arms the write-once latch
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      det_flag_q <= PWC_RST_PMC1[P1_FLAG_BIT];
      det_ie_q   <= PWC_RST_PMC1[P1_IE_BIT];
      det_re_q   <= PWC_RST_PMC1[P1_RE_BIT];
      det_se_q   <= PWC_RST_PMC1[P1_SE_BIT];
      det_en_q   <= PWC_RST_PMC1[P1_EN_BIT];
      bg_q       <= PWC_RST_PMC1[P1_BG_BIT];
      p1_wr_q    <= 1'b0;
    end else begin
      det_flag_q <= det_flag_d;
      det_ie_q   <= det_ie_d;
      det_re_q   <= det_re_d;
      det_se_q   <= det_se_d;
      det_en_q   <= det_en_d;
      bg_q       <= bg_d;
      p1_wr_q    <= p1_wr_d;
    end
  end

  // warning and stop-mode registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      warn_flag_q <= PWC_RST_PMC2[P2_WFLAG_BIT];
      dtrip_q     <= PWC_RST_PMC2[P2_DTRIP_BIT];
      wtrip_q     <= PWC_RST_PMC2[P2_WTRIP_BIT];
      ppd_flag_q  <= PWC_RST_PMC2[P2_PFLAG_BIT];
      partial_power_down_control_q      <= PWC_RST_PMC2[P2_PARTIAL_POWER_DOWN_CONTROL_BIT];
      p2_wr_q     <= 1'b0;
    end else begin
      warn_flag_q <= warn_flag_d;
      dtrip_q     <= dtrip_d;
      wtrip_q     <= wtrip_d;
      ppd_flag_q  <= ppd_flag_d;
      partial_power_down_control_q      <= partial_power_down_control_d;
      p2_wr_q     <= p2_wr_d;
    end
  end

  // bus answer registers; the idle cycle after ack blocks a double take
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dat_q <= '0;
      ack_q <= 1'b0;
      bus_q <= PWC_BUS_IDLE;
    end else begin
      dat_q <= dat_d;
      ack_q <= ack_d;
      bus_q <= bus_d;
    end
  end

  // output flops; all pins low during and right after reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_w_q   <= 1'b0;
      irq_d_q   <= 1'b0;
      rst_req_q <= 1'b0;
      act_q     <= 1'b0;
    end else begin
      irq_w_q   <= irq_w_d;
      irq_d_q   <= irq_d_d;
      rst_req_q <= rst_req_d;
      act_q     <= act_d;
    end
  end

  // outputs straight from flip-flops
  assign wb_dat_o              = dat_q;
  assign wb_ack_o              = ack_q;
  assign wakeup_irq            = irq_w_q;
  assign detect_irq            = irq_d_q;
  assign detect_reset_req      = rst_req_q;
  assign detect_active         = act_q;
  assign detect_trip_high      = dtrip_q;
  assign warning_trip_high     = wtrip_q;
  assign bandgap_buffer_enable = bg_q;
  assign stop2_select          = partial_power_down_control_q;
endmodule
`default_nettype wire

// *** verilog/pwc_pkg.sv ***
// package: register map, field positions, reset values and timing for the wakeup/power control block
package pwc_pkg;
  // word offsets on the bus (byte addresses, one aligned word each)
  localparam logic [3:0] PWC_OFS_WAKEUP = 4'h0;
  localparam logic [3:0] PWC_OFS_PMC1   = 4'h4;
  localparam logic [3:0] PWC_OFS_PMC2   = 4'h8;
  localparam logic [3:0] PWC_OFS_STATUS = 4'hC;

  // wakeup_timer_status_control fields
  localparam int WT_FLAG_BIT   = 7;
  localparam int WT_ACK_BIT    = 6;
  localparam int WT_SRC_BIT    = 5;
  localparam int WT_IE_BIT     = 4;
  localparam int WT_PER_MSB    = 2;

  // power_management_control_one fields
  localparam int P1_FLAG_BIT   = 7;
  localparam int P1_ACK_BIT    = 6;
  localparam int P1_IE_BIT     = 5;
  localparam int P1_RE_BIT     = 4;
  localparam int P1_SE_BIT     = 3;
  localparam int P1_EN_BIT     = 2;
  localparam int P1_BG_BIT     = 0;

  // power_management_control_two fields
  localparam int P2_WFLAG_BIT  = 7;
  localparam int P2_WACK_BIT   = 6;
  localparam int P2_DTRIP_BIT  = 5;
  localparam int P2_WTRIP_BIT  = 4;
  localparam int P2_PFLAG_BIT  = 3;
  localparam int P2_PACK_BIT   = 2;
  localparam int P2_PARTIAL_POWER_DOWN_CONTROL_BIT   = 0;

  // reset values: every control bit clears on reset
  localparam logic [7:0] PWC_RST_WAKEUP = 8'h00;
  localparam logic [7:0] PWC_RST_PMC1   = 8'h00;
  localparam logic [7:0] PWC_RST_PMC2   = 8'h00;

  // timer: periods counted in slow-clock ticks
  localparam int WT_SLOW_TICKS_1K_8MS = 8;
  localparam int WT_CNT_W             = 16;

  typedef enum logic [1:0] {
    PWC_BUS_IDLE,
    PWC_BUS_ACK
  } pwc_bus_state_t;
endpackage

// *** verif/pwc_asserts.sv ***
// concurrent checks on the wakeup and power control register bank ports
`timescale 1ns/1ps
`default_nettype none
module pwc_asserts (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        detect_trip_high,
  input wire logic        warning_trip_high,
  input wire logic        bandgap_buffer_enable,
  input wire logic        stop2_select
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // read acknowledge qualifier
  logic rd_ack;
  assign rd_ack = wb_ack_o && !wb_we_i;
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_ack_wait; wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:2] wb_ack_o; endproperty
  a_ack_wait: assert property (p_ack_wait) else $error("request not answered");
  property p_hi_zero; rd_ack && wb_adr_i != 4'hC |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits not zero");
  property p_wt_rsvd; rd_ack && wb_adr_i == 4'h0 |-> !wb_dat_o[6] && !wb_dat_o[3]; endproperty
  a_wt_rsvd: assert property (p_wt_rsvd) else $error("timer ack or spare bit reads one");
  property p_p1_rsvd; rd_ack && wb_adr_i == 4'h4 |-> !wb_dat_o[6] && !wb_dat_o[1]; endproperty
  a_p1_rsvd: assert property (p_p1_rsvd) else $error("pmc1 ack or spare bit reads one");
  property p_p2_rsvd; rd_ack && wb_adr_i == 4'h8 |-> (wb_dat_o[6:1] & 6'h23) == 6'h0; endproperty
  a_p2_rsvd: assert property (p_p2_rsvd) else $error("pmc2 ack or spare bit reads one");
  property p_unmap; wb_ack_o && wb_adr_i[1:0] != 2'b00 |-> wb_dat_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_trip;
    rd_ack && wb_adr_i == 4'h8 |=> detect_trip_high == $past(wb_dat_o[5])
      && warning_trip_high == $past(wb_dat_o[4]) && stop2_select == $past(wb_dat_o[0]);
  endproperty
  a_trip: assert property (p_trip) else $error("trip or stop outputs differ from pmc2");
  property p_bg; rd_ack && wb_adr_i == 4'h4 |=> bandgap_buffer_enable == $past(wb_dat_o[0]); endproperty
  a_bg: assert property (p_bg) else $error("bandgap enable differs from pmc1");
endmodule
bind pwc_top pwc_asserts u_chk (.core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .detect_trip_high, .warning_trip_high, .bandgap_buffer_enable, .stop2_select);
`default_nettype wire

// *** verif/pwc_top_tb_top.sv ***
// self-checking bench for the wakeup and power control register bank
`timescale 1ns/1ps
`default_nettype none
module pwc_top_tb_top;
  import pwc_pkg::*;
  logic        core_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] dat = 32'h0, q, wb_dat_o;
  logic        t1k = 1'b0, t32 = 1'b0, det = 1'b0, wrn = 1'b0, stp = 1'b0, rec = 1'b0, wb_ack_o;
  logic        wakeup_irq, detect_irq, detect_reset_req, detect_active;
  logic        detect_trip_high, warning_trip_high, bandgap_buffer_enable, stop2_select;
  int          error_cnt = 0;
  int          compares = 0;
  // 125 MHz core clock
  always #4 core_clk = ~core_clk;
  pwc_top dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tick_1k(t1k), .tick_32k(t32), .detect_level(det), .warning_level(wrn), .in_stop(stp),
    .stop2_recovered(rec), .wakeup_irq(wakeup_irq), .detect_irq(detect_irq),
    .detect_reset_req(detect_reset_req), .detect_active(detect_active), .detect_trip_high(detect_trip_high),
    .warning_trip_high(warning_trip_high), .bandgap_buffer_enable(bandgap_buffer_enable),
    .stop2_select(stop2_select));
  task automatic report_and_stop;
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge core_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      report_and_stop();
    end
    q = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask
  // one-cycle slow ticks spaced by an idle cycle
  task automatic tk(input logic s, input int n);
    repeat (n) begin
      @(posedge core_clk);
      if (s) t32 <= 1'b1; else t1k <= 1'b1;
      @(posedge core_clk);
      t32 <= 1'b0; t1k <= 1'b0;
    end
  endtask
  task automatic rst;
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask
  task automatic t_regs;
    rdc(PWC_OFS_WAKEUP, PWC_RST_WAKEUP);
    rdc(PWC_OFS_PMC1, PWC_RST_PMC1);
    rdc(PWC_OFS_PMC2, PWC_RST_PMC2);
    rdc(4'h1, 8'h00);
    wr(4'h1, 8'hFF);
    rdc(PWC_OFS_WAKEUP, 8'h00);
  endtask
  // every period code, other source ticking meanwhile (long 32k codes left out for run time)
  task automatic t_timer;
    int per[10] = '{8, 32, 64, 128, 256, 512, 1024, 256, 1024, 2048};
    logic s;
    logic [2:0] c;
    for (int i = 0; i < 10; i++) begin
      s = (i > 6);
      c = s ? 3'(i - 6) : 3'(i + 1);
      wr(PWC_OFS_WAKEUP, {2'b00, s, 2'b10, c});
      tk(s, per[i] - 1);
      tk(!s, per[i]);
      rdc(PWC_OFS_WAKEUP, {2'b00, s, 2'b10, c});
      tk(s, 1);
      rdc(PWC_OFS_WAKEUP, {2'b10, s, 2'b10, c});
      chk({31'h0, wakeup_irq}, 32'h1);
      wr(PWC_OFS_WAKEUP, {2'b00, s, 2'b00, c});
      rdc(PWC_OFS_WAKEUP, {2'b10, s, 2'b00, c});
      chk({31'h0, wakeup_irq}, 32'h0);
      wr(PWC_OFS_WAKEUP, {2'b01, s, 2'b00, c});
      rdc(PWC_OFS_WAKEUP, {2'b00, s, 2'b00, c});
    end
    wr(PWC_OFS_WAKEUP, 8'h10);
    tk(1'b0, 20);
    rdc(PWC_OFS_WAKEUP, 8'h10);
  endtask
  task automatic t_detect;
    rst();
    wr(PWC_OFS_PMC1, 8'h20);
    det <= 1'b1;
    rdc(PWC_OFS_PMC1, 8'h20);
    chk({31'h0, detect_irq}, 32'h0);
    wr(PWC_OFS_PMC1, 8'h14);
    rdc(PWC_OFS_PMC1, 8'h00);
    rst();
    wr(PWC_OFS_PMC1, 8'h3D);
    rdc(PWC_OFS_PMC1, 8'hBD);
    chk({28'h0, detect_irq, detect_reset_req, bandgap_buffer_enable, detect_active}, 32'hF);
    det <= 1'b0;
    wr(PWC_OFS_PMC1, 8'h69);
    rdc(PWC_OFS_PMC1, 8'h3D);
    stp <= 1'b1;
    wr(PWC_OFS_PMC1, 8'h35);
    det <= 1'b1;
    rdc(PWC_OFS_PMC1, 8'h35);
    chk({31'h0, detect_active}, 32'h0);
    det <= 1'b0; stp <= 1'b0;
  endtask
  task automatic t_pmc2;
    wr(PWC_OFS_PMC2, 8'h31);
    rdc(PWC_OFS_PMC2, 8'h31);
    chk({29'h0, detect_trip_high, warning_trip_high, stop2_select}, 32'h7);
    wr(PWC_OFS_PMC2, 8'h00);
    rdc(PWC_OFS_PMC2, 8'h01);
    wrn <= 1'b1;
    wr(PWC_OFS_PMC2, 8'h40);
    rdc(PWC_OFS_PMC2, 8'h81);
    wrn <= 1'b0;
    rdc(PWC_OFS_PMC2, 8'h81);
    wr(PWC_OFS_PMC2, 8'h40);
    rdc(PWC_OFS_PMC2, 8'h01);
    rec <= 1'b1;
    @(posedge core_clk);
    rec <= 1'b0;
    rdc(PWC_OFS_PMC2, 8'h09);
    wr(PWC_OFS_PMC2, 8'h04);
    rdc(PWC_OFS_PMC2, 8'h01);
  endtask
  // main sequence
  initial begin
    rst();
    t_regs();
    t_timer();
    t_detect();
    rst();
    t_pmc2();
    report_and_stop();
  end
endmodule
`default_nettype wire
